/* File: cfl_core.sv */
// Contract
// - Fetch of next word overlaps execution, one instruction per clock; the code takes two clocks for a two-word instruction.
// - Thirty-two eight-bit working registers, single-cycle access.
// - ALU reads two registers, computes, writes back in one cycle.
// - Six top registers form three 16-bit pointers; one reaches program tables.
// - Instructions are one or two 16-bit words; decoder handles both.
// - With boot section, self-program only acts from boot area.
// - Without boot section, self-program works from anywhere.
// - Vectors one word apart on small parts, two on large.
// - Interrupt or call pushes return address to stack in SRAM; the code writes only its low byte.
// - Lowest pending vector number is served first.
// - 64 I/O addresses, direct or at data 0x20 to 0x5F.
// - Extended I/O 0x60 to 0xFF only via data-space access.
// - Flags updated after every ALU operation.
// - Bit 7 global enable; clear blocks every interrupt.
// - Enable cleared on accept, set on return, set/clear by instructions.
// - Bit 6 bit-copy: store copies register bit in, load copies out.
// - Bit 5 half carry out of the low nibble.
// - Bit 4 sign equals negative xor overflow.
// - Bit 3 two's complement overflow.
// - Bit 2 negative result.
// - Bit 1 zero result, bit 0 carry.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module cfl_core
   import cfl_pkg::*;
(
   // Clock and reset
   input  wire logic                  mclk_i,
   input  wire logic                  resetn_i,
   // Program memory
   output logic [CFL_PC_W-1:0]        pmem_addr_o,
   input  wire logic [15:0]           pmem_data_i,
   // Data memory / I/O bus
   output logic [15:0]                dmem_addr_o,
   output logic [7:0]                 dmem_wdata_o,
   output logic                       dmem_we_o,
   output logic                       io_sel_o,
   output logic [5:0]                 io_idx_o,
   output logic                       ext_sel_o,
   // Self-programming
   output logic                       spm_go_o,
   output logic [15:0]                spm_addr_o,
   // Interrupts
   input  wire logic [CFL_NIRQ-1:0]   irq_i,
   output logic                       irq_ack_o,
   output logic [2:0]                 irq_num_o,
   // Register port
   input  wire logic [7:0]            reg_addr_i,
   input  wire logic [7:0]            reg_wdata_i,
   input  wire logic                  reg_wr_i,
   input  wire logic                  reg_rd_i,
   output logic [7:0]                 reg_rdata_o,
   // Status
   output logic [7:0]                 core_flags_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // State
   logic [7:0]          gpr [CFL_NREGS];
   logic [7:0]          core_flags;
   logic [7:0]          cfg;
   logic [CFL_PC_W-1:0] pc;
   logic [15:0]         stack_pointer;
   logic [15:0]         ir;
   logic [15:0]         ir_hold;
   logic                drop;
   cfl_state_t          state;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode
   cfl_instr_t ins;
   assign ins = cfl_instr_t'(ir);

   wire logic [7:0]  opa      = gpr[ins.rd];
   wire logic [7:0]  opb      = ins.use_imm ? {3'h0, ins.rr} : gpr[ins.rr];
   wire logic        cin      = core_flags[CFL_F_C];
   wire logic        is_sub   = (ins.op == CFL_OP_SUB) || (ins.op == CFL_OP_SBC);
   wire logic        use_c    = (ins.op == CFL_OP_ADC) || (ins.op == CFL_OP_SBC);
   wire logic [7:0]  opb_x    = is_sub ? ~opb : opb;
   wire logic        c_in_x   = is_sub ? ~(use_c & cin) : (use_c & cin);
   wire logic [8:0]  sum      = 9'(opa) + 9'(opb_x) + 9'(c_in_x);
   wire logic [4:0]  nib      = 5'(opa[3:0]) + 5'(opb_x[3:0]) + 5'(c_in_x);
   wire logic        is_arith = (ins.op >= CFL_OP_ADD) && (ins.op <= CFL_OP_SBC);
   wire logic        is_logic = (ins.op >= CFL_OP_AND) && (ins.op <= CFL_OP_EOR);
   wire logic [2:0]  bsel     = ins.rr[2:0];

   logic [7:0] result;
   always_comb
   begin
      unique case (ins.op)
         CFL_OP_AND: result = opa & opb;
         CFL_OP_OR:  result = opa | opb;
         CFL_OP_EOR: result = opa ^ opb;
         CFL_OP_MOV: result = opb;
         CFL_OP_BLD: result = (opa & ~(8'h01 << bsel)) |
                              ({7'h00, core_flags[CFL_F_T]} << bsel);
         default:    result = sum[7:0];
      endcase
   end

   wire logic        res_n    = result[7];
   wire logic        res_v    = is_arith ? ((opa[7] == opb_x[7]) && (sum[7] != opa[7])) : 1'b0;
   wire logic        res_c    = is_sub ? ~sum[8] : sum[8];
   wire logic        res_h    = is_sub ? ~nib[4] : nib[4];
   wire logic        alu_op   = is_arith || is_logic;
   wire logic        wr_gpr   = alu_op || (ins.op == CFL_OP_MOV) || (ins.op == CFL_OP_BLD);

   // Interrupt priority: lowest index wins
   logic [2:0] irq_pick;
   always_comb
   begin
      irq_pick = 3'h0;
      for (int i = CFL_NIRQ - 1; i >= 0; i--)
         if (irq_i[i])
            irq_pick = 3'(i);
   end
   wire logic take_irq = core_flags[CFL_F_I] && (|irq_i) && (state == CFL_ST_RUN);
   // Four bits so that request 7 does not wrap onto the reset vector
   wire logic [3:0]  vec_n    = 4'(irq_pick) + 4'h1;
   wire logic [CFL_PC_W-1:0] vec_addr = cfg[CFL_CFG_VEC2] ?
        CFL_PC_W'({vec_n, 1'b0}) : CFL_PC_W'(vec_n);

   // Self-programming permission
   wire logic in_boot = pc >= CFL_BOOT_START;
   wire logic spm_ok  = !cfg[CFL_CFG_BOOT] || in_boot;
   wire logic [15:0] z_ptr = {gpr[CFL_PTR_Z + 5'h1], gpr[CFL_PTR_Z]};
   wire logic [15:0] x_ptr = {gpr[CFL_PTR_X + 5'h1], gpr[CFL_PTR_X]};
   wire logic [15:0] y_ptr = {gpr[CFL_PTR_Y + 5'h1], gpr[CFL_PTR_Y]};
   // Pointer select: rr[1:0] 0=X 1=Y 2=Z, imm bit clear = data-space access
   wire logic [15:0] d_addr = (ins.rr[1:0] == 2'h0) ? x_ptr :
                              (ins.rr[1:0] == 2'h1) ? y_ptr : z_ptr;
   wire cfl_dspace_t dsp = cfl_decode_addr(d_addr, ins.use_imm);

   ////////////////////////////////////////////////////////////////////////////////
   // Register port decode
   wire logic wr_flags = reg_wr_i && (reg_addr_i == CFL_REG_FLAGS);
   wire logic wr_cfg   = reg_wr_i && (reg_addr_i == CFL_REG_CFG);
   logic [7:0] next_rdata;
   always_comb
   begin
      unique case (reg_addr_i)
         CFL_REG_FLAGS: next_rdata = core_flags;
         CFL_REG_CFG:   next_rdata = cfg;
         CFL_REG_PCL:   next_rdata = pc[7:0];
         CFL_REG_PCH:   next_rdata = {2'h0, pc[CFL_PC_W-1:8]};
         CFL_REG_STAT:  next_rdata = {5'h0, irq_pick};
         default:       next_rdata = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next flags
   logic [7:0] next_flags;
   always_comb
   begin
      next_flags = core_flags;
      if (wr_flags)
         next_flags = reg_wdata_i;
      else if (take_irq)
         next_flags[CFL_F_I] = 1'b0;
      else if (state == CFL_ST_RUN)
      begin
         if (alu_op)
         begin
            next_flags[CFL_F_N] = res_n;
            next_flags[CFL_F_Z] = cfl_is_zero(result);
            next_flags[CFL_F_V] = res_v;
            next_flags[CFL_F_S] = res_n ^ res_v;
            if (is_arith)
            begin
               next_flags[CFL_F_C] = res_c;
               next_flags[CFL_F_H] = res_h;
            end
         end
         unique case (ins.op)
            CFL_OP_BST:  next_flags[CFL_F_T] = opa[bsel];
            CFL_OP_SEI,
            CFL_OP_RETURN_FROM_IRQ_INSTR: next_flags[CFL_F_I] = 1'b1;
            CFL_OP_CLI:  next_flags[CFL_F_I] = 1'b0;
            default:     ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer: one clock per single-word instruction, two for a long word, fetch of pc overlaps execute of ir
   wire logic is_call = (ins.op == CFL_OP_CALL) && (state == CFL_ST_RUN);
   wire logic [CFL_PC_W-1:0] ret_pc = take_irq ? pc - CFL_PC_W'(1) : pc;
   logic [CFL_PC_W-1:0] next_pc;
   always_comb
   begin
      if (take_irq)
         next_pc = vec_addr;
      else if (state == CFL_ST_WORD && ins.op == CFL_OP_CALL)
         next_pc = ir_hold[CFL_PC_W-1:0];
      else
         next_pc = pc + CFL_PC_W'(1);
   end

   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         core_flags    <= CFL_FLAGS_RST;
         cfg           <= CFL_CFG_RST;
         pc            <= CFL_PC_RST;
         ir            <= 16'h0000;
         ir_hold       <= 16'h0000;
         drop          <= 1'b1;
         state         <= CFL_ST_RUN;
         stack_pointer <= 16'hffff;
         reg_rdata_o   <= 8'h00;
         core_flags_o  <= CFL_FLAGS_RST;
      end
      else
      begin
         core_flags   <= next_flags;
         core_flags_o <= next_flags;
         pc           <= next_pc;
         // Fetch word after a redirect belongs to the old address
         drop         <= take_irq || (state == CFL_ST_WORD && ins.op == CFL_OP_CALL);
         reg_rdata_o  <= reg_rd_i ? next_rdata : 8'h00;
         if (wr_cfg)
            cfg <= reg_wdata_i;
         if (take_irq || (state == CFL_ST_WORD && ins.op == CFL_OP_CALL))
            stack_pointer <= stack_pointer - 16'h0002;
         else if (state == CFL_ST_RUN && ins.op == CFL_OP_RETURN_FROM_IRQ_INSTR)
            stack_pointer <= stack_pointer + 16'h0002;
         unique case (state)
            CFL_ST_RUN:
            begin
               if (!take_irq && ins.long_word)
               begin
                  state   <= CFL_ST_WORD;
                  ir_hold <= pmem_data_i;
               end
               else
                  ir <= (take_irq || drop) ? 16'h0000 : pmem_data_i;
            end
            CFL_ST_WORD:
            begin
               state <= CFL_ST_RUN;
               ir    <= 16'h0000;
            end
            default: state <= CFL_ST_RUN;
         endcase
      end
   end

   // Register file write-back in the same cycle
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         for (int i = 0; i < CFL_NREGS; i++)
            gpr[i] <= 8'h00;
      end
      else if (state == CFL_ST_RUN && !take_irq && wr_gpr)
         gpr[ins.rd] <= result;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bus outputs, registered
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         pmem_addr_o  <= CFL_PC_RST;
         dmem_addr_o  <= 16'h0000;
         dmem_wdata_o <= 8'h00;
         dmem_we_o    <= 1'b0;
         io_sel_o     <= 1'b0;
         io_idx_o     <= 6'h00;
         ext_sel_o    <= 1'b0;
         spm_go_o     <= 1'b0;
         spm_addr_o   <= 16'h0000;
         irq_ack_o    <= 1'b0;
         irq_num_o    <= 3'h0;
      end
      else
      begin
         pmem_addr_o  <= next_pc;
         irq_ack_o    <= take_irq;
         irq_num_o    <= irq_pick;
         spm_go_o     <= (ins.op == CFL_OP_SPM) && (state == CFL_ST_RUN) && spm_ok;
         spm_addr_o   <= z_ptr;
         if (take_irq || is_call)
         begin
            dmem_addr_o  <= stack_pointer;
            dmem_wdata_o <= ret_pc[7:0];
            dmem_we_o    <= 1'b1;
            io_sel_o     <= 1'b0;
            ext_sel_o    <= 1'b0;
         end
         else
         begin
            dmem_addr_o  <= d_addr;
            dmem_wdata_o <= opa;
            dmem_we_o    <= (ins.op == CFL_OP_NOP) && ins.long_word && (state == CFL_ST_RUN);
            io_sel_o     <= dsp.io;
            ext_sel_o    <= dsp.ext;
         end
         io_idx_o <= dsp.io_idx & CFL_IO_SIZE_M1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   a_irq_gate_off: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      !core_flags[CFL_F_I] |=> !irq_ack_o)
      else $error("interrupt taken while disabled");
   a_irq_clears_i: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      take_irq && !wr_flags |=> !core_flags[CFL_F_I])
      else $error("enable not cleared on accept");
   a_sign_rule: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      $past(alu_op && state == CFL_ST_RUN && !take_irq && !wr_flags) |->
      core_flags[CFL_F_S] == (core_flags[CFL_F_N] ^ core_flags[CFL_F_V]))
      else $error("sign not n xor v");
   a_zero_flag: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      alu_op && state == CFL_ST_RUN && !take_irq && !wr_flags |=>
      core_flags[CFL_F_Z] == cfl_is_zero($past(result)))
      else $error("zero flag wrong");
   a_neg_flag: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      alu_op && state == CFL_ST_RUN && !take_irq && !wr_flags |=>
      core_flags[CFL_F_N] == $past(result[7]))
      else $error("negative flag wrong");
   a_return_from_irq_instr_sets_i: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      ins.op == CFL_OP_RETURN_FROM_IRQ_INSTR && state == CFL_ST_RUN && !take_irq && !wr_flags
      |=> core_flags[CFL_F_I])
      else $error("return did not enable");
   a_spm_boot: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      cfg[CFL_CFG_BOOT] && !in_boot |=> !spm_go_o)
      else $error("self program outside boot");
   a_io_window: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      io_sel_o |-> dmem_addr_o >= 16'h0020 && dmem_addr_o <= 16'h005f)
      else $error("io select outside window");
   a_push_on_irq: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      take_irq |=> dmem_we_o && pc == $past(vec_addr))
      else $error("no push on interrupt");
   a_vec_prio: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      take_irq && irq_i[0] |-> irq_pick == 3'h0)
      else $error("priority wrong");
   a_flags_reset: assert property (@(posedge mclk_i)
      !resetn_i |=> core_flags == 8'h00)
      else $error("flags not cleared by reset");

   c_irq_taken: cover property (@(posedge mclk_i) disable iff (!resetn_i) irq_ack_o);
   c_long_word: cover property (@(posedge mclk_i) disable iff (!resetn_i)
      state == CFL_ST_WORD);
   c_spm_go:    cover property (@(posedge mclk_i) disable iff (!resetn_i) spm_go_o);
   c_carry_set: cover property (@(posedge mclk_i) disable iff (!resetn_i)
      core_flags[CFL_F_C] && core_flags[CFL_F_H]);

endmodule : cfl_core

/* File: cfl_mem_model.sv */
`timescale 1ns/1ps
module cfl_mem_model
   import cfl_pkg::*;
(
   // Clock
   input  wire logic                mclk_i,
   // Program memory
   input  wire logic [CFL_PC_W-1:0] pmem_addr_i,
   output logic [15:0]              pmem_data_o,
   // Data memory
   input  wire logic [15:0]         dmem_addr_i,
   input  wire logic [7:0]          dmem_wdata_i,
   input  wire logic                dmem_we_i
);
   logic [15:0] prog [0:255];
   logic [7:0]  dram [0:255];
   int          n_push = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // Synchronous fetch: the word answers last cycle's address; only 256 words kept
   always_ff @(posedge mclk_i)
   begin
      pmem_data_o <= prog[pmem_addr_i[7:0]];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Stack bytes land in SRAM, aliased into 256 bytes
   always @(posedge mclk_i)
   begin
      if (dmem_we_i)
      begin
         dram[dmem_addr_i[7:0]] <= dmem_wdata_i;
         n_push                 <= n_push + 1;
      end
   end
endmodule : cfl_mem_model

/* File: cfl_pkg.sv */
package cfl_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Geometry
   localparam int          CFL_NREGS      = 32;
   localparam int          CFL_PC_W       = 14;
   localparam int          CFL_NIRQ       = 8;
   localparam logic [7:0]  CFL_IO_LO      = 8'h20;
   localparam logic [7:0]  CFL_IO_HI      = 8'h5f;
   localparam logic [7:0]  CFL_EXT_LO     = 8'h60;
   localparam logic [7:0]  CFL_EXT_HI     = 8'hff;
   localparam logic [5:0]  CFL_IO_SIZE_M1 = 6'h3f;
   localparam logic [4:0]  CFL_PTR_X      = 5'h1a;
   localparam logic [4:0]  CFL_PTR_Y      = 5'h1c;
   localparam logic [4:0]  CFL_PTR_Z      = 5'h1e;

   ////////////////////////////////////////////////////////////////////////////////
   // Flag bit positions and reset value
   localparam int          CFL_F_I        = 7;
   localparam int          CFL_F_T        = 6;
   localparam int          CFL_F_H        = 5;
   localparam int          CFL_F_S        = 4;
   localparam int          CFL_F_V        = 3;
   localparam int          CFL_F_N        = 2;
   localparam int          CFL_F_Z        = 1;
   localparam int          CFL_F_C        = 0;
   localparam logic [7:0]  CFL_FLAGS_RST  = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Register port offsets (chosen)
   localparam logic [7:0]  CFL_REG_FLAGS  = 8'h00;
   localparam logic [7:0]  CFL_REG_CFG    = 8'h01;
   localparam logic [7:0]  CFL_REG_PCL    = 8'h02;
   localparam logic [7:0]  CFL_REG_PCH    = 8'h03;
   localparam logic [7:0]  CFL_REG_STAT   = 8'h04;
   localparam int          CFL_CFG_BOOT   = 0;
   localparam int          CFL_CFG_VEC2   = 1;
   localparam logic [7:0]  CFL_CFG_RST    = 8'h01;
   localparam logic [CFL_PC_W-1:0] CFL_BOOT_START = 14'h3800;
   localparam logic [CFL_PC_W-1:0] CFL_PC_RST     = 14'h0000;

   ////////////////////////////////////////////////////////////////////////////////
   // Operations
   typedef enum logic [3:0] {
      CFL_OP_NOP  = 4'h0,
      CFL_OP_ADD  = 4'h1,
      CFL_OP_ADC  = 4'h2,
      CFL_OP_SUB  = 4'h3,
      CFL_OP_SBC  = 4'h4,
      CFL_OP_AND  = 4'h5,
      CFL_OP_OR   = 4'h6,
      CFL_OP_EOR  = 4'h7,
      CFL_OP_MOV  = 4'h8,
      CFL_OP_BST  = 4'h9,
      CFL_OP_BLD  = 4'ha,
      CFL_OP_SEI  = 4'hb,
      CFL_OP_CLI  = 4'hc,
      CFL_OP_RETURN_FROM_IRQ_INSTR = 4'hd,
      CFL_OP_SPM  = 4'he,
      CFL_OP_CALL = 4'hf
   } cfl_op_t;

   typedef enum logic [1:0] {
      CFL_ST_RUN  = 2'b01,
      CFL_ST_WORD = 2'b10
   } cfl_state_t;

   // Decoded instruction word: op[15:12] d[11:7] r[6:2] long[1] imm[0]
   typedef struct packed {
      cfl_op_t    op;
      logic [4:0] rd;
      logic [4:0] rr;
      logic       long_word;
      logic       use_imm;
   } cfl_instr_t;

   typedef struct packed {
      logic       hit;
      logic       io;
      logic       ext;
      logic [5:0] io_idx;
   } cfl_dspace_t;

   function automatic cfl_dspace_t cfl_decode_addr(input logic [15:0] a, input logic direct);
      cfl_dspace_t d;
      d.io     = (a >= {8'h00, CFL_IO_LO}) && (a <= {8'h00, CFL_IO_HI});
      d.ext    = !direct && (a >= {8'h00, CFL_EXT_LO}) && (a <= {8'h00, CFL_EXT_HI});
      d.io_idx = 6'(a - {8'h00, CFL_IO_LO});
      d.hit    = d.io || d.ext;
      return d;
   endfunction : cfl_decode_addr

   function automatic logic cfl_is_zero(input logic [7:0] v);
      return v == 8'h00;
   endfunction : cfl_is_zero

endpackage : cfl_pkg

/* File: cpu_core_status_flags_tb.sv */
`timescale 1ns/1ps
module cpu_core_status_flags_tb;
   import cfl_pkg::*;
   logic                mclk_i;
   logic                resetn_i;
   logic [CFL_PC_W-1:0] pmem_addr;
   logic [15:0]         pmem_data;
   logic [15:0]         dmem_addr;
   logic [7:0]          dmem_wdata;
   logic                dmem_we;
   logic                spm_go;
   logic [7:0]          irq;
   logic                irq_ack;
   logic [2:0]          irq_num;
   logic [7:0]          reg_addr;
   logic [7:0]          reg_wdata;
   logic                reg_wr;
   logic                reg_rd;
   logic [7:0]          reg_rdata;
   logic [7:0]          flags;
   logic [7:0]          v;
   logic [CFL_PC_W-1:0] pc0;
   int                  n_fail = 0;
   int                  compares = 0;
   int                  n_ack = 0;
   int                  n_spm = 0;
   int                  i;

   cfl_core u_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .pmem_addr_o(pmem_addr),
      .pmem_data_i(pmem_data), .dmem_addr_o(dmem_addr), .dmem_wdata_o(dmem_wdata),
      .dmem_we_o(dmem_we), .io_sel_o(), .io_idx_o(), .ext_sel_o(), .spm_go_o(spm_go),
      .spm_addr_o(), .irq_i(irq), .irq_ack_o(irq_ack), .irq_num_o(irq_num),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_rdata_o(reg_rdata), .core_flags_o(flags));

   cfl_mem_model u_mem (.mclk_i(mclk_i), .pmem_addr_i(pmem_addr), .pmem_data_o(pmem_data),
      .dmem_addr_i(dmem_addr), .dmem_wdata_i(dmem_wdata), .dmem_we_i(dmem_we));

   initial
   begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end

   // Pulse counters for acknowledge and self-program
   always @(posedge mclk_i)
   begin
      if (irq_ack === 1'b1) n_ack++;
      if (spm_go === 1'b1) n_spm++;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic conclude;
      $display("checks %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude

   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge mclk_i);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk_i);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(logic [7:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk_i);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   // Program stays loaded while reset holds, so fetch starts clean
   task automatic restart;
      @(posedge mclk_i);
      resetn_i <= 1'b0;
      repeat (16) @(posedge mclk_i);
      resetn_i <= 1'b1;
      @(posedge mclk_i);
   endtask : restart

   task automatic clear_prog;
      for (int k = 0; k < 256; k++) u_mem.prog[k] = 16'h0000;
   endtask : clear_prog

   function automatic logic [15:0] enc(cfl_op_t op, logic [4:0] rd, logic [4:0] rr, logic im);
      return {op, rd, rr, 1'b0, im};
   endfunction : enc

   // Returns {result, next flags}; zero results of borrow-chained ops are avoided
   function automatic logic [15:0] alu(cfl_op_t op, logic [7:0] a, logic [7:0] b,
                                       logic [7:0] f);
      logic [8:0] r;
      logic       ci;
      logic       ov;
      ci = (op == CFL_OP_ADC || op == CFL_OP_SBC) ? f[CFL_F_C] : 1'b0;
      ov = 1'b0;
      case (op)
         CFL_OP_ADD, CFL_OP_ADC:
         begin
            r          = a + b + ci;
            f[CFL_F_H] = (a[3:0] + b[3:0] + ci) > 5'h0f;
            ov         = (a[7] == b[7]) && (r[7] != a[7]);
            f[CFL_F_C] = r[8];
         end
         CFL_OP_SUB, CFL_OP_SBC:
         begin
            r          = a - b - ci;
            f[CFL_F_H] = a[3:0] < (b[3:0] + ci);
            ov         = (a[7] != b[7]) && (r[7] != a[7]);
            f[CFL_F_C] = r[8];
         end
         CFL_OP_AND: r = a & b;
         CFL_OP_OR:  r = a | b;
         default:    r = a ^ b;
      endcase
      f[CFL_F_V] = ov;
      f[CFL_F_N] = r[7];
      f[CFL_F_S] = r[7] ^ ov;
      f[CFL_F_Z] = (r[7:0] == 8'h00);
      return {r[7:0], f};
   endfunction : alu

   // Load a, b; double both dbl times; then op r1,r2
   task automatic run_alu(cfl_op_t op, logic [4:0] a, logic [4:0] b, int dbl);
      logic [15:0] x;
      logic [7:0]  r1;
      logic [7:0]  r2;
      logic [7:0]  f;
      int          pc;
      r1 = {3'h0, a};
      r2 = {3'h0, b};
      f  = CFL_FLAGS_RST;
      clear_prog();
      u_mem.prog[0] = enc(CFL_OP_MOV, 5'h01, a, 1'b1);
      u_mem.prog[1] = enc(CFL_OP_MOV, 5'h02, b, 1'b1);
      pc = 2;
      repeat (dbl)
      begin
         u_mem.prog[pc]   = enc(CFL_OP_ADD, 5'h01, 5'h01, 1'b0);
         u_mem.prog[pc+1] = enc(CFL_OP_ADD, 5'h02, 5'h02, 1'b0);
         pc += 2;
         x  = alu(CFL_OP_ADD, r1, r1, f);
         r1 = x[15:8];
         x  = alu(CFL_OP_ADD, r2, r2, x[7:0]);
         r2 = x[15:8];
         f  = x[7:0];
      end
      u_mem.prog[pc] = enc(op, 5'h01, 5'h02, 1'b0);
      x = alu(op, r1, r2, f);
      restart();
      repeat (30) @(posedge mclk_i);
      chk("flags out", flags, x[7:0]);
      rd(CFL_REG_FLAGS, v);
      chk("flags reg", v, x[7:0]);
   endtask : run_alu

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      resetn_i  = 1'b0;
      irq       = 8'h00;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      clear_prog();
      irq <= 8'hff;
      restart();
      rd(CFL_REG_FLAGS, v);
      chk("flags reset", v, CFL_FLAGS_RST);
      rd(CFL_REG_CFG, v);
      chk("cfg reset", v, CFL_CFG_RST);
      wr(8'h10, 8'h5a);
      rd(8'h10, v);
      chk("unmapped", v, 8'h00);
      repeat (20) @(posedge mclk_i);
      chk("masked ack", 8'(n_ack), 8'h00);
      #1 pc0 = pmem_addr;
      @(posedge mclk_i);
      #1 chk("fetch step", 8'(pmem_addr - pc0), 8'h01);
      irq <= 8'h00;
      wr(CFL_REG_FLAGS, 8'ha5);
      rd(CFL_REG_FLAGS, v);
      chk("flags write", v, 8'ha5);
      chk("flags port", flags, 8'ha5);
      $display("test reset and register port done");

      run_alu(CFL_OP_ADD, 5'h07, 5'h09, 0);
      run_alu(CFL_OP_ADD, 5'h10, 5'h10, 2);
      run_alu(CFL_OP_ADD, 5'h10, 5'h10, 3);
      run_alu(CFL_OP_SUB, 5'h01, 5'h02, 0);
      run_alu(CFL_OP_SUB, 5'h05, 5'h05, 0);
      run_alu(CFL_OP_ADC, 5'h10, 5'h10, 4);
      run_alu(CFL_OP_SBC, 5'h10, 5'h10, 4);
      run_alu(CFL_OP_AND, 5'h10, 5'h10, 3);
      run_alu(CFL_OP_OR, 5'h10, 5'h01, 3);
      run_alu(CFL_OP_EOR, 5'h05, 5'h05, 0);
      $display("test alu flags done");

      // Vector of request 6 is word 7, clear of the opening code
      clear_prog();
      u_mem.prog[0] = enc(CFL_OP_SEI, 5'h00, 5'h00, 1'b0);
      u_mem.prog[7] = enc(CFL_OP_RETURN_FROM_IRQ_INSTR, 5'h00, 5'h00, 1'b0);
      n_ack = 0;
      irq <= 8'hc0;
      restart();
      for (i = 0; i < 50 && irq_ack !== 1'b1; i++)
      begin
         @(posedge mclk_i);
         #1;
      end
      if (i == 50)
      begin
         n_fail++;
         conclude();
      end
      chk("irq number", {5'h00, irq_num}, 8'h06);
      chk("return push", {7'h00, dmem_we}, 8'h01);
      chk("enable cleared", {7'h00, flags[CFL_F_I]}, 8'h00);
      @(posedge mclk_i);
      irq <= 8'h00;
      repeat (20) @(posedge mclk_i);
      chk("enable on return", {7'h00, flags[CFL_F_I]}, 8'h01);
      chk("single ack", 8'(n_ack), 8'h01);
      chk("push count", 8'(u_mem.n_push), 8'h01);
      chk("flags after return", flags, 8'h80);
      u_mem.prog[1] = enc(CFL_OP_CLI, 5'h00, 5'h00, 1'b0);
      u_mem.prog[7] = 16'h0000;
      restart();
      repeat (20) @(posedge mclk_i);
      chk("enable by clear", flags, 8'h00);
      $display("test interrupt done");

      clear_prog();
      u_mem.prog[8] = enc(CFL_OP_SPM, 5'h00, 5'h00, 1'b0);
      n_spm = 0;
      restart();
      repeat (30) @(posedge mclk_i);
      chk("spm outside boot", 8'(n_spm), 8'h00);
      restart();
      wr(CFL_REG_CFG, 8'h00);
      repeat (30) @(posedge mclk_i);
      chk("spm no boot", 8'(n_spm), 8'h01);
      $display("test self program done");
      conclude();
   end

   initial
   begin
      #200000;
      n_fail++;
      conclude();
   end
endmodule : cpu_core_status_flags_tb
